// file: rtl/cte_defs.svh
/*
 * Constants of the pulse command table executor: table sizes, field widths
 * and timing counts.
 * Assumes it is included by its bare name wherever the figures are needed.
 */
`ifndef CTE_DEFS_SVH
`define CTE_DEFS_SVH

// =====================================================================
// Storage sizes
`define CTE_CT_DEPTH      4096
`define CTE_WT_DEPTH      16000
`define CTE_IMEM_DEPTH    32768
`define CTE_MIN_WAVE_LEN  16
`define CTE_FIFO_DEPTH    16

// =====================================================================
// Field widths
`define CTE_CT_IDX_W      12
`define CTE_WT_IDX_W      14
`define CTE_PHASE_W       16
`define CTE_AMP_W         16
`define CTE_OSC_IDX_W     1
`define CTE_NUM_OSC       2
`define CTE_FREQ_W        32
`define CTE_PROG_LEN_W    16
`define CTE_WAVE_LEN_W    20

// =====================================================================
// Timing: one entry per sequencer cycle, direct play costs two cycles
`define CTE_SEQ_CYCLE_NS  4
`define CTE_CLK_PERIOD_NS 100
`define CTE_EXEC_CYCLES   ((`CTE_SEQ_CYCLE_NS / `CTE_CLK_PERIOD_NS) < 1 ? 1 : \
                           (`CTE_SEQ_CYCLE_NS / `CTE_CLK_PERIOD_NS))
`define CTE_PLAY_CYCLES   2

`endif

// file: rtl/cte_pkg.sv
/*
 * Types of the pulse command table executor.
 * Assumes cte_defs.svh is reachable on the include path.
 */
`include "cte_defs.svh"

package cte_pkg;

    // =====================================================================
    // One command table entry
    typedef struct packed {
        logic [`CTE_WT_IDX_W-1:0] wave;
        logic phase_set;
        logic phase_inc;
        logic [`CTE_PHASE_W-1:0] phase;
        logic amp_set;
        logic amp_inc;
        logic [4*`CTE_AMP_W-1:0] amp;
        logic osc_set;
        logic [`CTE_OSC_IDX_W-1:0] osc;
    } entry_s;

    // =====================================================================
    // Instruction front end states, one-hot
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_PLAY = 2'b10
    } state_e;

endpackage

// file: rtl/pulse_command_table_executor.sv
/*
 * Pulse command table executor with its playback FIFO.
 * Assumes one clock, synchronous inputs, and a playback engine that drains
 * the wave index FIFO with valid/ready.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cte_defs.svh"

// =====================================================================
// Wave index FIFO with registered output stage
module cte_fifo #(
    parameter int WIDTH = `CTE_WT_IDX_W,
    parameter int DEPTH = `CTE_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [$clog2(DEPTH+1)-1:0] cnt_q;
    logic push;
    logic pop;

    // Pop into the output stage whenever it is empty or being drained
    assign in_ready = (cnt_q != ($clog2(DEPTH+1))'(DEPTH));
    assign push = ce && in_valid && in_ready;
    assign pop = ce && (cnt_q != '0) && (!out_valid || out_ready);
    assign level = cnt_q;

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Output stage, so the consumer sees flops only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (ce) begin
            if (pop) begin
                out_valid <= 1'b1;
                out_data <= mem[rd_q];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// =====================================================================
// Executor top
module pulse_command_table_executor
    import cte_pkg::*;
#(
    parameter int CT_DEPTH = `CTE_CT_DEPTH,
    parameter int WT_DEPTH = `CTE_WT_DEPTH,
    parameter int IMEM_DEPTH = `CTE_IMEM_DEPTH,
    parameter int FIFO_DEPTH = `CTE_FIFO_DEPTH,
    parameter int NUM_OSC = `CTE_NUM_OSC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PROG_LOAD,
    input wire logic [`CTE_PROG_LEN_W-1:0] PROG_LEN,
    output logic LOAD_ERR,
    input wire logic BIND_EN,
    input wire logic [`CTE_WT_IDX_W-1:0] BIND_INDEX,
    input wire logic [`CTE_WAVE_LEN_W-1:0] BIND_LEN,
    input wire logic CT_WR_EN,
    input wire logic [`CTE_CT_IDX_W-1:0] CT_WR_INDEX,
    input wire logic [`CTE_WT_IDX_W-1:0] CT_WR_WAVE,
    input wire logic CT_WR_PHASE_SET,
    input wire logic CT_WR_PHASE_INC,
    input wire logic [`CTE_PHASE_W-1:0] CT_WR_PHASE,
    input wire logic CT_WR_AMP_SET,
    input wire logic CT_WR_AMP_INC,
    input wire logic [4*`CTE_AMP_W-1:0] CT_WR_AMP,
    input wire logic CT_WR_OSC_SET,
    input wire logic [`CTE_OSC_IDX_W-1:0] CT_WR_OSC,
    input wire logic EXEC_VALID,
    input wire logic [`CTE_CT_IDX_W-1:0] EXEC_INDEX,
    input wire logic PLAY_VALID,
    input wire logic [`CTE_WT_IDX_W-1:0] PLAY_WAVE,
    output logic INSTR_READY,
    output logic REFUSED,
    input wire logic WAVE_WR_EN,
    input wire logic [`CTE_WT_IDX_W-1:0] WAVE_WR_INDEX,
    output logic WAVE_WR_GO,
    output logic [`CTE_WT_IDX_W-1:0] WAVE_WR_SLOT,
    input wire logic [`CTE_PHASE_W-1:0] HOST_PHASE,
    input wire logic [4*`CTE_AMP_W-1:0] HOST_AMP,
    input wire logic [NUM_OSC*`CTE_FREQ_W-1:0] OSC_FREQ,
    output logic [`CTE_PHASE_W-1:0] PHASE,
    output logic [4*`CTE_AMP_W-1:0] AMP,
    output logic [`CTE_OSC_IDX_W-1:0] OSC_SEL,
    output logic [`CTE_PHASE_W-1:0] OSC_PHASE,
    output logic PB_VALID,
    input wire logic PB_READY,
    output logic [`CTE_WT_IDX_W-1:0] PB_WAVE
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    // Held value update: add in incremental mode, replace otherwise
    function automatic logic [`CTE_AMP_W-1:0] apply_val(input logic inc, input logic [`CTE_AMP_W-1:0] cur,
                                                         input logic [`CTE_AMP_W-1:0] val);
        apply_val = inc ? cur + val : val;
    endfunction

    entry_s table_q [0:CT_DEPTH-1];
    logic ct_ok_q [0:CT_DEPTH-1];
    logic wave_ok_q [0:WT_DEPTH-1];
    logic [`CTE_FREQ_W-1:0] acc_q [0:NUM_OSC-1];
    state_e state_q;
    logic [`CTE_WT_IDX_W-1:0] play_wave_q;
    logic override_q;
    entry_s ent;
    logic exec_fire;
    logic play_fire;
    logic exec_ok;
    logic play_ok;
    logic push_valid;
    logic [`CTE_WT_IDX_W-1:0] push_wave;
    logic fifo_in_ready;
    logic [LW-1:0] fifo_level;

    // =====================================================================
    // Instruction decode; a program load in the same cycle drops both
    assign ent = table_q[EXEC_INDEX];
    assign exec_fire = CE && EXEC_VALID && INSTR_READY && !PROG_LOAD;
    assign play_fire = CE && PLAY_VALID && INSTR_READY && !PROG_LOAD && !EXEC_VALID;
    assign exec_ok = exec_fire && ct_ok_q[EXEC_INDEX] && wave_ok_q[ent.wave];
    assign play_ok = wave_ok_q[play_wave_q];
    assign push_valid = exec_ok || (CE && state_q == S_PLAY && play_ok && !PROG_LOAD);
    assign push_wave = exec_ok ? ent.wave : play_wave_q;

    // Command table upload, independent of instructions and waveforms
    always_ff @(posedge CLK) begin
        if (CE && CT_WR_EN) begin
            table_q[CT_WR_INDEX] <= '{wave: CT_WR_WAVE, phase_set: CT_WR_PHASE_SET, phase_inc: CT_WR_PHASE_INC,
                                      phase: CT_WR_PHASE, amp_set: CT_WR_AMP_SET, amp_inc: CT_WR_AMP_INC,
                                      amp: CT_WR_AMP, osc_set: CT_WR_OSC_SET, osc: CT_WR_OSC};
        end
    end

    // Entry defined flags; a load wipes the table, an upload wins over it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < CT_DEPTH; i++) begin
                ct_ok_q[i] <= 1'b0;
            end
        end else if (CE) begin
            if (PROG_LOAD) begin
                for (int i = 0; i < CT_DEPTH; i++) begin
                    ct_ok_q[i] <= 1'b0;
                end
            end
            if (CT_WR_EN) begin
                ct_ok_q[CT_WR_INDEX] <= 1'b1;
            end
        end
    end

    // Wave slot binding; too-short waves stay unbound as a safety net
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < WT_DEPTH; i++) begin
                wave_ok_q[i] <= 1'b0;
            end
        end else if (CE) begin
            if (PROG_LOAD) begin
                for (int i = 0; i < WT_DEPTH; i++) begin
                    wave_ok_q[i] <= 1'b0;
                end
            end
            if (BIND_EN && 32'(BIND_INDEX) < WT_DEPTH) begin
                wave_ok_q[BIND_INDEX] <= (BIND_LEN >= `CTE_WAVE_LEN_W'(`CTE_MIN_WAVE_LEN));
            end
        end
    end

    // Program size check at load
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            LOAD_ERR <= 1'b0;
        end else if (CE && PROG_LOAD) begin
            LOAD_ERR <= (32'(PROG_LEN) > IMEM_DEPTH);
        end
    end

    // Sticky refusal; a load clears it, and an instruction in the load cycle is dropped, not refused
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REFUSED <= 1'b0;
        end else if (CE) begin
            if ((exec_fire && !exec_ok) || (state_q == S_PLAY && !play_ok && !PROG_LOAD)) begin
                REFUSED <= 1'b1;
            end else if (PROG_LOAD) begin
                REFUSED <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Direct play occupies a second cycle, entries never do
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= S_IDLE;
            play_wave_q <= '0;
        end else if (CE) begin
            case (state_q)
                S_IDLE: begin
                    if (play_fire) begin
                        state_q <= S_PLAY;
                        play_wave_q <= PLAY_WAVE;
                    end
                end
                S_PLAY: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Ready kept two words short of full since it lags by one cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            INSTR_READY <= 1'b0;
        end else if (CE) begin
            INSTR_READY <= !play_fire && !PROG_LOAD && fifo_in_ready && (fifo_level <= LW'(FIFO_DEPTH - 2));
        end
    end

    // =====================================================================
    // Phase and amplitude: table values beat the host values for good once an entry sets the phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PHASE <= '0;
            override_q <= 1'b0;
        end else if (CE) begin
            if (exec_ok && ent.phase_set) begin
                PHASE <= apply_val(ent.phase_inc, PHASE, ent.phase);
                override_q <= 1'b1;
            end else if (!override_q) begin
                PHASE <= HOST_PHASE;
            end
        end
    end

    // Four amplitude coefficients, one shared mode bit per entry
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            AMP <= '0;
        end else if (CE) begin
            for (int k = 0; k < 4; k++) begin
                if (exec_ok && ent.amp_set) begin
                    AMP[k*`CTE_AMP_W +: `CTE_AMP_W] <= apply_val(ent.amp_inc, AMP[k*`CTE_AMP_W +: `CTE_AMP_W],
                                                                 ent.amp[k*`CTE_AMP_W +: `CTE_AMP_W]);
                end else if (!override_q) begin
                    AMP[k*`CTE_AMP_W +: `CTE_AMP_W] <= HOST_AMP[k*`CTE_AMP_W +: `CTE_AMP_W];
                end
            end
        end
    end

    // Oscillators run free so a switch lands on a continuous phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < NUM_OSC; i++) begin
                acc_q[i] <= '0;
            end
        end else if (CE) begin
            for (int i = 0; i < NUM_OSC; i++) begin
                acc_q[i] <= acc_q[i] + OSC_FREQ[i*`CTE_FREQ_W +: `CTE_FREQ_W];
            end
        end
    end

    // Oscillator selection and modulated phase output
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            OSC_SEL <= '0;
            OSC_PHASE <= '0;
        end else if (CE) begin
            if (exec_ok && ent.osc_set) begin
                OSC_SEL <= ent.osc;
            end
            OSC_PHASE <= acc_q[OSC_SEL][`CTE_FREQ_W-1 -: `CTE_PHASE_W] + PHASE;
        end
    end

    // Host waveform writes addressed by a bound wave index
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WAVE_WR_GO <= 1'b0;
            WAVE_WR_SLOT <= '0;
        end else if (CE) begin
            WAVE_WR_GO <= WAVE_WR_EN && 32'(WAVE_WR_INDEX) < WT_DEPTH && wave_ok_q[WAVE_WR_INDEX];
            WAVE_WR_SLOT <= WAVE_WR_INDEX;
        end
    end

    // =====================================================================
    // Playback start queue
    cte_fifo #(
        .WIDTH(`CTE_WT_IDX_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_wave),
        .out_valid(PB_VALID),
        .out_ready(PB_READY),
        .out_data(PB_WAVE),
        .level(fifo_level)
    );
endmodule

`default_nettype wire

// file: testbench/cte_asserts.sv
/* Port checker for the pulse command table executor.
   Assumes it is bound onto the executor top: one clock, RST async high. */
`timescale 1ns/1ns
`default_nettype none
`include "cte_defs.svh"
// ==========
// Port relations
module cte_asserts #(
    parameter int IMEM_DEPTH = 32768
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PROG_LOAD,
    input wire logic [`CTE_PROG_LEN_W-1:0] PROG_LEN,
    input wire logic LOAD_ERR,
    input wire logic EXEC_VALID,
    input wire logic PLAY_VALID,
    input wire logic INSTR_READY,
    input wire logic REFUSED,
    input wire logic WAVE_WR_EN,
    input wire logic [`CTE_WT_IDX_W-1:0] WAVE_WR_INDEX,
    input wire logic WAVE_WR_GO,
    input wire logic [`CTE_WT_IDX_W-1:0] WAVE_WR_SLOT,
    input wire logic [`CTE_PHASE_W-1:0] PHASE,
    input wire logic [4*`CTE_AMP_W-1:0] AMP,
    input wire logic [`CTE_OSC_IDX_W-1:0] OSC_SEL,
    input wire logic PB_VALID,
    input wire logic PB_READY,
    input wire logic [`CTE_WT_IDX_W-1:0] PB_WAVE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Length guard registered one cycle after the load
    property p_load_err;
        PROG_LOAD && CE |=> LOAD_ERR == ($past(PROG_LEN) > IMEM_DEPTH);
    endproperty
    a_load_err: assert property (p_load_err) else $error("load error flag wrong");
    property p_load_hold;
        !PROG_LOAD |=> $stable(LOAD_ERR);
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("load error flag moved");
    // Direct play must cost a second cycle
    property p_play_gap;
        CE && INSTR_READY && !PROG_LOAD && PLAY_VALID && !EXEC_VALID |=> !INSTR_READY;
    endproperty
    a_play_gap: assert property (p_play_gap) else $error("play took one cycle");
    // Refusal stays until a new program arrives
    property p_ref_sticky;
        REFUSED && !PROG_LOAD |=> REFUSED;
    endproperty
    a_ref_sticky: assert property (p_ref_sticky) else $error("refusal dropped");
    property p_ref_cause;
        $rose(REFUSED) |-> $past(EXEC_VALID) || $past(PLAY_VALID, 2);
    endproperty
    a_ref_cause: assert property (p_ref_cause) else $error("refusal without request");
    // A refused entry leaves settings untouched
    property p_ref_keep;
        $rose(REFUSED) |-> $stable(PHASE) && $stable(AMP) && $stable(OSC_SEL);
    endproperty
    a_ref_keep: assert property (p_ref_keep) else $error("refused entry changed settings");
    property p_osc_cause;
        $changed(OSC_SEL) |-> $past(EXEC_VALID && INSTR_READY);
    endproperty
    a_osc_cause: assert property (p_osc_cause) else $error("oscillator moved alone");
    property p_pb_hold;
        PB_VALID && !PB_READY && !PROG_LOAD |=> PB_VALID && $stable(PB_WAVE);
    endproperty
    a_pb_hold: assert property (p_pb_hold) else $error("playback word lost");
    property p_wave_wr;
        WAVE_WR_GO |-> $past(WAVE_WR_EN) && WAVE_WR_SLOT == $past(WAVE_WR_INDEX);
    endproperty
    a_wave_wr: assert property (p_wave_wr) else $error("waveform write slot wrong");
endmodule
bind pulse_command_table_executor cte_asserts #(.IMEM_DEPTH(IMEM_DEPTH)) i_cte_asserts (.CLK, .RST, .CE,
    .PROG_LOAD, .PROG_LEN, .LOAD_ERR, .EXEC_VALID, .PLAY_VALID, .INSTR_READY, .REFUSED, .WAVE_WR_EN,
    .WAVE_WR_INDEX, .WAVE_WR_GO, .WAVE_WR_SLOT, .PHASE, .AMP, .OSC_SEL, .PB_VALID, .PB_READY, .PB_WAVE);
`default_nettype wire

// file: testbench/pb_sink.sv
/* Playback engine model draining the wave index stream.
   Assumes the bench stalls it through the stall input. */
`timescale 1ns/1ns
`default_nettype none
`include "cte_defs.svh"
// ==========
// Sink
module pb_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic pb_valid,
    input wire logic [`CTE_WT_IDX_W-1:0] pb_wave,
    output logic pb_ready,
    output int rx_count,
    output logic [`CTE_WT_IDX_W-1:0] last_wave
);
    assign pb_ready = !stall;
    // One word per playback start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_count <= 0;
            last_wave <= '0;
        end else if (pb_valid && pb_ready) begin
            rx_count <= rx_count + 1;
            last_wave <= pb_wave;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb_pulse_command_table_executor.sv
/* Self-checking bench for the command table executor.
   Assumes the checker is bound and the sink model drains playback. */
`timescale 1ns/1ns
`default_nettype none
`include "cte_defs.svh"
// ==========
// Bench
module tb_pulse_command_table_executor;
    import cte_pkg::*;
    logic clk = 1'b0, rst = 1'b1, pload = 1'b0, b_en = 1'b0, ct_en = 1'b0, ex_v = 1'b0, pl_v = 1'b0;
    logic ww_en = 1'b0, stall = 1'b0, load_err, ready, refused, ww_go, pb_valid, pb_ready, osc_sel;
    logic ce = 1'b1;
    logic [15:0] osc_ph, ph0;
    logic [15:0] plen = '0, host_ph = 16'h1234, phase;
    logic [13:0] b_idx = '0, pl_w = '0, ww_idx = '0, ww_slot, pb_wave, last_wave;
    logic [19:0] b_len = '0;
    logic [11:0] ct_idx = '0, ex_idx = '0;
    logic [63:0] host_amp = 64'h1111_2222_3333_4444, amp;
    entry_s ent = '0;
    int err_count = 0, num_checks = 0, rx_count, n;
    always #50 clk = ~clk;
    pulse_command_table_executor i_pulse_command_table_executor (.CLK(clk), .RST(rst), .CE(ce),
        .PROG_LOAD(pload), .PROG_LEN(plen), .LOAD_ERR(load_err), .BIND_EN(b_en), .BIND_INDEX(b_idx),
        .BIND_LEN(b_len), .CT_WR_EN(ct_en), .CT_WR_INDEX(ct_idx), .CT_WR_WAVE(ent.wave),
        .CT_WR_PHASE_SET(ent.phase_set), .CT_WR_PHASE_INC(ent.phase_inc), .CT_WR_PHASE(ent.phase),
        .CT_WR_AMP_SET(ent.amp_set), .CT_WR_AMP_INC(ent.amp_inc), .CT_WR_AMP(ent.amp),
        .CT_WR_OSC_SET(ent.osc_set), .CT_WR_OSC(ent.osc), .EXEC_VALID(ex_v), .EXEC_INDEX(ex_idx),
        .PLAY_VALID(pl_v), .PLAY_WAVE(pl_w), .INSTR_READY(ready), .REFUSED(refused), .WAVE_WR_EN(ww_en),
        .WAVE_WR_INDEX(ww_idx), .WAVE_WR_GO(ww_go), .WAVE_WR_SLOT(ww_slot), .HOST_PHASE(host_ph),
        .HOST_AMP(host_amp), .OSC_FREQ(64'h0000_1000_0000_0100), .PHASE(phase), .AMP(amp),
        .OSC_SEL(osc_sel), .OSC_PHASE(osc_ph), .PB_VALID(pb_valid), .PB_READY(pb_ready), .PB_WAVE(pb_wave));
    pb_sink i_pb_sink (.clk(clk), .rst(rst), .stall(stall), .pb_valid(pb_valid), .pb_wave(pb_wave),
        .pb_ready(pb_ready), .rx_count(rx_count), .last_wave(last_wave));
    // ==========
    // Helpers: inputs move 1 ns after the rising edge
    task tick; @(posedge clk); #1; endtask
    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task load(input logic [15:0] len); plen = len; pload = 1; tick; pload = 0; endtask
    // Leaves the request up so entries can run back to back
    task exec(input logic [11:0] idx);
        ex_idx = idx;
        ex_v = 1;
        repeat (40) if (!ready) tick;
        tick;
    endtask
    task ct_wr(input logic [11:0] idx, input entry_s e); ct_idx = idx; ent = e; ct_en = 1; tick; ct_en = 0; endtask
    // ==========
    // Scenarios
    task t_setup;
        check("phase", phase, host_ph);
        load(16'h0064);
        b_idx = 5; b_len = 20'h0_0040; b_en = 1; tick; b_en = 0;
        ct_wr(0, '{14'h0005, 1, 0, 16'h0100, 1, 0, 64'h0400_0300_0200_0100, 1, 1'b1});
        ct_wr(1, '{14'h0005, 1, 1, 16'h0010, 1, 1, 64'h0001_0001_0001_0001, 0, 1'b0});
        ct_wr(2, '{14'h0007, 1, 0, 16'h0999, 0, 0, 64'h0, 0, 1'b0});
    endtask
    task t_exec;
        exec(0);
        check("phase", phase, 16'h0100);
        check("amp", amp, 64'h0400_0300_0200_0100);
        check("osc", osc_sel, 1'b1);
        exec(1);
        ex_v = 0;
        check("phase", phase, 16'h0110);
        check("amp", amp, 64'h0401_0301_0201_0101);
        host_ph = 16'h4321;
        repeat (4) tick;
        check("phase", phase, 16'h0110);
        check("osc", osc_sel, 1'b1);
        check("count", rx_count, 2);
        check("wave", last_wave, 14'h0005);
        // Free-running oscillator: 16 steps of 0x1000 lift the top half by one
        ph0 = osc_ph;
        repeat (16) tick;
        check("osc phase", 16'(osc_ph - ph0), 16'h0001);
        // Clock enable low freezes everything
        ce = 0;
        ph0 = osc_ph;
        repeat (3) tick;
        check("frozen", osc_ph, ph0);
        ce = 1;
    endtask
    task t_play;
        pl_w = 5; pl_v = 1;
        repeat (40) if (!ready) tick;
        tick;
        pl_v = 0;
        check("ready", ready, 1'b0);
        repeat (4) tick;
        check("count", rx_count, 3);
    endtask
    task t_wave;
        ww_idx = 5; ww_en = 1; tick; ww_idx = 6; tick; ww_en = 0;
        check("go", ww_go, 1'b0);
        ww_idx = 5; ww_en = 1; tick; ww_en = 0;
        check("go", ww_go, 1'b1);
        check("slot", ww_slot, 14'h0005);
    endtask
    // Fill the buffer against a stalled sink, then drain it
    task t_fifo;
        stall = 1; n = 0; ex_idx = 0; ex_v = 1;
        repeat (30) begin
            if (ready) n++;
            tick;
        end
        ex_v = 0;
        check("accepted", n, `CTE_FIFO_DEPTH + 1);
        check("ready", ready, 1'b0);
        stall = 0;
        repeat (40) tick;
        check("count", rx_count, 3 + n);
    endtask
    task t_refuse;
        exec(2);
        ex_v = 0;
        check("refused", refused, 1'b1);
        check("phase", phase, 16'h0100);
        load(16'h8001);
        check("load err", load_err, 1'b1);
        check("refused", refused, 1'b0);
        load(16'h8000);
        check("load err", load_err, 1'b0);
        exec(0);
        ex_v = 0;
        check("refused", refused, 1'b1);
    endtask
    initial begin
        repeat (8) tick;
        rst = 0;
        repeat (2) tick;
        t_setup;
        t_exec;
        t_play;
        t_wave;
        t_fifo;
        t_refuse;
        complete_run;
    end
    initial begin
        #2000000;
        err_count++;
        complete_run;
    end
endmodule
`default_nettype wire
